// ==== bench/aupf_adc_model.sv ====
`timescale 1ns/1ps
// two external converters on one frame clock; bits change after the
// falling bit clock so they are settled at the rising edge
module aupf_adc_model
	import aupf_pkg::*;
(
	input  wire logic        i_bclk,
	input  wire logic        i_run,
	input  wire logic        i_on_main,
	input  wire logic [6:0]  i_half_bits,
	input  wire logic [23:0] i_word_a,
	input  wire logic [23:0] i_word_b,
	output logic             o_frame_main,
	output logic             o_frame_aux,
	output logic             o_data_a,
	output logic             o_data_b,
	output logic             o_sent,
	output aupf_sample_t     o_sent_a,
	output aupf_sample_t     o_sent_b
);
	logic        busy = 1'b0;
	logic        left = 1'b0;
	logic [7:0]  pos = 8'h00;
	logic [7:0]  idx = 8'h00;
	logic [23:0] wa = 24'h000000;
	logic [23:0] wb = 24'h000000;

	initial begin
		o_frame_main = 1'b0;
		o_frame_aux = 1'b0;
		o_data_a = 1'b0;
		o_data_b = 1'b0;
		o_sent = 1'b0;
	end

	always @(negedge i_bclk) begin
		o_sent <= 1'b0;
		if (!busy && i_run) begin
			busy = 1'b1;
			pos = 8'h00;
			wa = i_word_a;
			wb = i_word_b;
		end
		left = busy && (pos < {1'b0, i_half_bits});
		idx = left ? pos : pos - {1'b0, i_half_bits};
		// msb first, 24 bits per half; spare slots sit at the pull-down level
		if (busy && idx < 8'h18) begin
			o_data_a <= left ? wa[8'h17 - idx] : ~wa[8'h17 - idx];
			o_data_b <= left ? wb[8'h17 - idx] : ~wb[8'h17 - idx];
		end else begin
			o_data_a <= 1'b0;
			o_data_b <= 1'b0;
		end
		if (busy && idx == 8'h17) begin
			o_sent <= 1'b1;
			o_sent_a <= {left, left ? wa : ~wa};
			o_sent_b <= {left, left ? wb : ~wb};
		end
		// only the port wired to the converters carries their frame clock
		o_frame_main <= i_on_main & left;
		o_frame_aux <= ~i_on_main & left;
		if (busy) begin
			pos = pos + 8'h01;
			if (pos == {i_half_bits, 1'b0})
				busy = 1'b0;
		end
	end
endmodule : aupf_adc_model

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import aupf_pkg::*;
	logic         clk, lclk, rst_n, adc_bit, spdif_bit, run, on_main;
	logic         fr_m, fr_a, d_a, d_b, sent, c_out, a_out, val_a, val_b;
	logic         r_err, f_err, m_err, act;
	logic [6:0]   half;
	logic [23:0]  w_a, w_b;
	logic [8:0]   period;
	logic [4:0]   lbits;
	logic [3:0]   dch, ach, sch;
	aupf_cfg_t    cfg;
	aupf_sample_t s_a, s_b, smp_a, smp_b;
	aupf_ratio_t  mr, ar;
	aupf_sample_t exp_a[$];
	aupf_sample_t exp_b[$];
	int           errors = 0;
	int           checks = 0;
	logic [1:0]   sel;
	logic [1:0]   pick;

	aupf_serial_port dut_u (.I_CLOCK(clk), .I_RESETN(rst_n),
		.I_EXT_ADC_BIT_CLOCK(lclk), .I_CONFIG(cfg),
		.I_CODEC_PORT_FRAME_CLOCK(fr_m), .I_AUX_PORT_FRAME_CLOCK(fr_a),
		.I_EXT_ADC_DATA_IN_A(d_a), .I_EXT_ADC_DATA_IN_B(d_b),
		.I_ADC_STREAM_BIT(adc_bit), .I_SPDIF_STREAM_BIT(spdif_bit),
		.O_CODEC_PORT_DATA_OUT(c_out), .O_AUX_PORT_DATA_OUT(a_out),
		.O_EXT_ADC_A(smp_a), .O_EXT_ADC_A_VALID(val_a),
		.O_EXT_ADC_B(smp_b), .O_EXT_ADC_B_VALID(val_b),
		.O_EXT_ADC_PERIOD(period), .O_EXT_ADC_RATE_ERROR(r_err),
		.O_FORMAT_ERROR(f_err), .O_MODE_ERROR(m_err),
		.O_CONFIG1_ACTIVE(act), .O_MAIN_BIT_RATIO(mr),
		.O_AUX_BIT_RATIO(ar), .O_LINE_SAMPLE_BITS(lbits),
		.O_DAC_CHANNELS(dch), .O_ADC_CHANNELS(ach), .O_SPDIF_CHANNELS(sch));

	aupf_adc_model model_u (.i_bclk(lclk), .i_run(run), .i_on_main(on_main),
		.i_half_bits(half), .i_word_a(w_a), .i_word_b(w_b),
		.o_frame_main(fr_m), .o_frame_aux(fr_a), .o_data_a(d_a),
		.o_data_b(d_b), .o_sent(sent), .o_sent_a(s_a), .o_sent_b(s_b));

	always #25 clk = ~clk;
	always #40 lclk = ~lclk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
			input string what);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// config 1 needs both ports master, aux clocks for the converters
	task automatic base(input aupf_speed_t s);
		cfg = '0;
		cfg.main_master = 1'b1;
		cfg.aux_master = 1'b1;
		cfg.ext_clk_sel = EXT_CLK_AUX;
		cfg.main_speed = s;
		cfg.aux_speed = s;
		cfg.main_ratio = RATIO_64;
		cfg.aux_ratio = RATIO_64;
	endtask : base

	task automatic fmt_case(input aupf_fmt_t f, input logic w, input logic m,
			input aupf_speed_t s, input aupf_ratio_t r, input logic e);
		base(s);
		cfg.fmt = f;
		cfg.wide_samples = w;
		cfg.main_master = m;
		cfg.aux_master = m;
		cfg.main_ratio = r;
		cfg.aux_ratio = r;
		tick(2);
		check(f_err, e, "format error");
	endtask : fmt_case

	task automatic mode_case(input aupf_line_t ad, input aupf_line_t da,
			input aupf_speed_t s, input logic e, input aupf_ratio_t m,
			input logic [4:0] b);
		base(s);
		cfg.adc_line = ad;
		cfg.dac_line = da;
		tick(2);
		check(m_err, e, "mode error");
		check(act, !e, "config active");
		check(mr, m, "main ratio");
		if (!e) begin
			check(ar, RATIO_64, "aux ratio");
			check(lbits, b, "sample bits");
			check({dch, ach, sch},
				{CFG1_DAC_CH, CFG1_ADC_CH, CFG1_SPDIF_CH}, "channels");
		end
	endtask : mode_case

	task automatic link_case(input aupf_speed_t s, input logic src,
			input logic on_m, input logic [6:0] h, input logic e);
		base(s);
		cfg.ext_clk_sel = src;
		cfg.fmt = aupf_fmt_t'(2'($urandom));
		on_main = on_m;
		half = h;
		w_a = 24'($urandom);
		w_b = 24'($urandom);
		tick(8);
		run = 1'b1;
		repeat (8 * h) @(posedge lclk);
		#1 run = 1'b0;
		repeat (2 * h + 8) @(posedge lclk);
		tick(8);
		if (src == on_m) begin
			check(period, {h, 1'b0}, "period");
			check(r_err, e, "rate error");
		end
		check(exp_a.size() + exp_b.size(), 0, "missing words");
		$display("test link speed %0d source %0d done", s, src);
	endtask : link_case

	// a word is expected only when the clock-source bit names the port
	always @(posedge lclk)
		if (sent === 1'b1 && on_main === cfg.ext_clk_sel) begin
			exp_a.push_back(s_a);
			exp_b.push_back(s_b);
		end

	// valid stands a whole cycle, so look mid-cycle, away from its launch
	always @(negedge clk) begin
		if (val_a === 1'b1)
			check(smp_a, exp_a.size() ? exp_a.pop_front() : '1, "adc a");
		if (val_b === 1'b1)
			check(smp_b, exp_b.size() ? exp_b.pop_front() : '1, "adc b");
	end

	initial begin
		#2000000;
		errors++;
		$display("unexpected at %0t: run hung", $time);
		complete_run();
	end

	initial begin
		{clk, lclk, rst_n, adc_bit, spdif_bit, run, on_main} = '0;
		{half, w_a, w_b} = '0;
		base(SPD_SINGLE);
		void'($urandom(32'h5eaa8c2d));
		repeat (3) @(posedge clk);
		check(mr, RATIO_NONE, "reset ratio");
		#1 rst_n = 1'b1;
		tick(3);
		fmt_case(FMT_I2S, 1'b0, 1'b1, SPD_SINGLE, RATIO_64, 1'b0);
		fmt_case(FMT_I2S, 1'b0, 1'b1, SPD_SINGLE, RATIO_128, 1'b1);
		fmt_case(FMT_I2S, 1'b0, 1'b0, SPD_SINGLE, RATIO_32, 1'b1);
		fmt_case(FMT_I2S, 1'b0, 1'b0, SPD_DOUBLE, RATIO_128, 1'b1);
		fmt_case(FMT_LEFT, 1'b1, 1'b1, SPD_SINGLE, RATIO_256, 1'b0);
		fmt_case(FMT_LEFT, 1'b1, 1'b1, SPD_DOUBLE, RATIO_128, 1'b1);
		fmt_case(FMT_LEFT, 1'b0, 1'b0, SPD_SINGLE, RATIO_32, 1'b0);
		fmt_case(FMT_RIGHT24, 1'b0, 1'b0, SPD_DOUBLE, RATIO_48, 1'b0);
		fmt_case(FMT_RIGHT24, 1'b0, 1'b0, SPD_QUAD, RATIO_32, 1'b1);
		fmt_case(FMT_RIGHT16, 1'b1, 1'b0, SPD_DOUBLE, RATIO_32, 1'b0);
		$display("test formats done");
		mode_case(OL_MODE1, OL_NONE, SPD_DOUBLE, 1'b0, RATIO_128, 5'h14);
		mode_case(OL_NONE, OL_MODE1, SPD_SINGLE, 1'b0, RATIO_128, 5'h14);
		mode_case(OL_MODE2, OL_MODE2, SPD_SINGLE, 1'b0, RATIO_256, 5'h18);
		mode_case(OL_MODE2, OL_NONE, SPD_SINGLE, 1'b0, RATIO_256, 5'h18);
		mode_case(OL_MODE2, OL_NONE, SPD_DOUBLE, 1'b1, RATIO_NONE, 5'h00);
		mode_case(OL_MODE1, OL_NONE, SPD_QUAD, 1'b1, RATIO_NONE, 5'h00);
		mode_case(OL_MODE2, OL_MODE1, SPD_SINGLE, 1'b1, RATIO_NONE, 5'h00);
		mode_case(OL_NONE, OL_MODE2, SPD_SINGLE, 1'b1, RATIO_NONE, 5'h00);
		for (int k = 0; k < 4; k++) begin
			base(SPD_SINGLE);
			cfg.adc_line = OL_MODE1;
			cfg.main_master = k != 0;
			cfg.aux_master = k != 1;
			cfg.ext_clk_sel = k == 2 ? EXT_CLK_MAIN : EXT_CLK_AUX;
			cfg.aux_speed = k == 3 ? SPD_DOUBLE : SPD_SINGLE;
			tick(2);
			check({m_err, act}, 2'b10, "config 1 setup");
		end
		$display("test modes done");
		for (int i = 0; i < 4; i++) begin
			base(SPD_SINGLE);
			cfg.adc_port_sel = i[1:0];
			sel = i[1:0];
			repeat (16) begin
				{adc_bit, spdif_bit} = 2'($urandom);
				pick = {adc_bit, spdif_bit};
				tick(1);
				check(c_out, sel == SEL_ADC_MAIN && pick[1], "main out");
				check(a_out, sel == SEL_ADC_MAIN ? pick[0] :
					sel == SEL_ADC_AUX && pick[1], "aux out");
			end
		end
		$display("test routing done");
		link_case(SPD_SINGLE, EXT_CLK_AUX, 1'b0, 7'h20, 1'b0);
		link_case(SPD_SINGLE, EXT_CLK_MAIN, 1'b1, 7'h40, 1'b0);
		link_case(SPD_DOUBLE, EXT_CLK_AUX, 1'b0, 7'h20, 1'b0);
		link_case(SPD_DOUBLE, EXT_CLK_AUX, 1'b0, 7'h40, 1'b1);
		link_case(SPD_QUAD, EXT_CLK_MAIN, 1'b1, 7'h20, 1'b1);
		link_case(SPD_SINGLE, EXT_CLK_MAIN, 1'b0, 7'h20, 1'b0);
		complete_run();
	end
endmodule : tb_top

// ==== logic/aupf_adc_deser.sv ====
`timescale 1ns/1ps
// left-justified 24-bit capture on rising bit clock; the msb sits at
// the first rising edge after the frame clock changes
module aupf_adc_deser
	import aupf_pkg::*;
(
	input  wire logic          i_clk,
	input  wire logic          i_rst_n,
	input  wire logic          i_frame,
	input  wire logic          i_data,
	output aupf_pkg::aupf_sample_t o_sample,
	output logic               o_toggle
);
	logic        frame_q;
	logic [4:0]  cnt_q;
	logic [22:0] shift_q;
	logic        start;

	assign start = i_frame != frame_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			frame_q <= 1'b0;
			cnt_q   <= ADC_BITS;
			shift_q <= '0;
		end else begin
			frame_q <= i_frame;
			if (start) begin
				shift_q <= {22'h0, i_data};
				cnt_q   <= ADC_FIRST;
			end else if (cnt_q < ADC_BITS) begin
				shift_q <= {shift_q[21:0], i_data};
				cnt_q   <= cnt_q + 5'h01;
			end
		end
	end

	// trailing bits of a 64 or 128 fs slot are ignored
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sample <= '0;
			o_toggle <= 1'b0;
		end else if (!start && cnt_q == ADC_LAST) begin // RL6
			o_sample <= {frame_q, shift_q, i_data};
			o_toggle <= ~o_toggle;
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	word_done_a: assert property (!start && cnt_q == ADC_LAST // RL6
		|=> o_toggle != $past(o_toggle) && o_sample.data[0] == $past(i_data))
		else $error("sample not delivered after 24th bit");
	msb_first_a: assert property (start ##1 (!start)[*8] // RL6
		|-> shift_q[7] == $past(i_data, 8))
		else $error("msb not kept at the head of the word");
endmodule : aupf_adc_deser

// ==== logic/aupf_pkg.sv ====
package aupf_pkg;
	typedef enum logic [1:0] {
		SPD_SINGLE = 2'h0,
		SPD_DOUBLE = 2'h1,
		SPD_QUAD   = 2'h2,
		SPD_RSVD   = 2'h3
	} aupf_speed_t;

	typedef enum logic [1:0] {
		OL_NONE  = 2'h0,
		OL_MODE1 = 2'h1,
		OL_MODE2 = 2'h2,
		OL_RSVD  = 2'h3
	} aupf_line_t;

	typedef enum logic [1:0] {
		FMT_LEFT    = 2'h0,
		FMT_I2S     = 2'h1,
		FMT_RIGHT16 = 2'h2,
		FMT_RIGHT24 = 2'h3
	} aupf_fmt_t;

	typedef enum logic [2:0] {
		RATIO_32   = 3'h0,
		RATIO_48   = 3'h1,
		RATIO_64   = 3'h2,
		RATIO_128  = 3'h3,
		RATIO_256  = 3'h4,
		RATIO_NONE = 3'h7
	} aupf_ratio_t;

	localparam logic [1:0] SEL_ADC_MAIN = 2'h0;
	localparam logic [1:0] SEL_ADC_AUX  = 2'h2;
	localparam logic       EXT_CLK_MAIN = 1'b1;
	localparam logic       EXT_CLK_AUX  = 1'b0;

	localparam int         ADC_WORD_BITS = 24;
	localparam logic [4:0] ADC_BITS      = 5'h18;
	localparam logic [4:0] ADC_LAST      = 5'h17;
	localparam logic [4:0] ADC_FIRST     = 5'h01;

	localparam logic [8:0] PERIOD_64  = 9'h040;
	localparam logic [8:0] PERIOD_128 = 9'h080;
	localparam logic [8:0] PERIOD_MAX = 9'h1ff;
	localparam logic [8:0] PERIOD_ONE = 9'h001;

	localparam logic [4:0] LINE1_BITS = 5'h14;
	localparam logic [4:0] LINE2_BITS = 5'h18;
	localparam logic [3:0] CFG1_DAC_CH   = 4'h8;
	localparam logic [3:0] CFG1_ADC_CH   = 4'h6;
	localparam logic [3:0] CFG1_SPDIF_CH = 4'h2;

	typedef struct packed {
		aupf_speed_t main_speed;
		aupf_speed_t aux_speed;
		aupf_line_t  adc_line;
		aupf_line_t  dac_line;
		logic [1:0]  adc_port_sel;
		aupf_fmt_t   fmt;
		logic        wide_samples;
		logic        main_master;
		logic        aux_master;
		logic        ext_clk_sel;
		aupf_ratio_t main_ratio;
		aupf_ratio_t aux_ratio;
	} aupf_cfg_t;

	typedef struct packed {
		logic                     left;
		logic [ADC_WORD_BITS-1:0] data;
	} aupf_sample_t;
endpackage : aupf_pkg

// ==== logic/aupf_serial_port.sv ====
`timescale 1ns/1ps
// Summary of operation
// [RL1] I2S 16-bit: master 64 fs; slave 48/64/128 single, 64 otherwise.
// [RL2] left-justified: master 64/128/256 single wide, else 64; slave ratios.
// [RL3] right-justified 16 or 24 bits, data on rising edge, slave 48/64; code: 24-bit also 128 single, 16-bit slave 32/64, 48/128 single.
// [RL4] one-line mode 1: 20 bits, 128 fs, single or double speed only.
// [RL5] one-line mode 2: 24 bits, 256 fs, single speed, master only.
// [RL6] external adc inputs: left-justified 24-bit words at 64 or 128 fs.
// [RL7] external adc format never follows any port format setting.
// [RL8] single speed: external adc bit clock 64 or 128 fs.
// [RL9] double speed: external adc bit clock 64 fs only.
// [RL10] quad speed: external adc inputs unsupported.
// [RL11] clock-source bit 1: capture external adcs with main port clocks.
// [RL12] clock-source bit 0: capture external adcs with aux port clocks.
// [RL13] config 1 carries 8 dac, 6 adc and 2 s/pdif channels.
// [RL14] config 1 alone gives 24-bit samples on all channels at 48 khz; code gives 24 bits only with a mode 2 line, 20 with mode 1.
// [RL15] config 1: both ports share one speed code and one frame clock.
// [RL16] port select 00: adc data on main output, s/pdif on aux output.
// [RL17] config 1 needs the main port as clock master.
// [RL18] config 1 needs the aux port as clock master.
// [RL19] config 1 needs the external adc clock source set to aux.
// [RL20] adc mode 2: main 256 fs single speed, aux 64; dac mode 1 invalid.
// [RL21] both ports offer five formats from 16 to 24 bits; code decodes four format codes, shared by both ports.
// [RL22] invalid mode combinations raise an error flag.
module aupf_serial_port
	import aupf_pkg::*;
(
	input  wire logic                I_CLOCK,
	input  wire logic                I_RESETN,
	input  wire logic                I_EXT_ADC_BIT_CLOCK,
	input  aupf_pkg::aupf_cfg_t      I_CONFIG,
	input  wire logic                I_CODEC_PORT_FRAME_CLOCK,
	input  wire logic                I_AUX_PORT_FRAME_CLOCK,
	input  wire logic                I_EXT_ADC_DATA_IN_A,
	input  wire logic                I_EXT_ADC_DATA_IN_B,
	input  wire logic                I_ADC_STREAM_BIT,
	input  wire logic                I_SPDIF_STREAM_BIT,
	output logic                     O_CODEC_PORT_DATA_OUT,
	output logic                     O_AUX_PORT_DATA_OUT,
	output aupf_pkg::aupf_sample_t   O_EXT_ADC_A,
	output logic                     O_EXT_ADC_A_VALID,
	output aupf_pkg::aupf_sample_t   O_EXT_ADC_B,
	output logic                     O_EXT_ADC_B_VALID,
	output logic [8:0]               O_EXT_ADC_PERIOD,
	output logic                     O_EXT_ADC_RATE_ERROR,
	output logic                     O_FORMAT_ERROR,
	output logic                     O_MODE_ERROR,
	output logic                     O_CONFIG1_ACTIVE,
	output aupf_pkg::aupf_ratio_t    O_MAIN_BIT_RATIO,
	output aupf_pkg::aupf_ratio_t    O_AUX_BIT_RATIO,
	output logic [4:0]               O_LINE_SAMPLE_BITS,
	output logic [3:0]               O_DAC_CHANNELS,
	output logic [3:0]               O_ADC_CHANNELS,
	output logic [3:0]               O_SPDIF_CHANNELS
);
	logic        rst_meta_q;
	logic        rst_n_q;
	logic        lrst_meta_q;
	logic        lrst_n_q;
	logic        sel_meta_q;
	logic        sel_q;
	logic        ext_frame;
	logic        lframe_q;
	logic        armed_q;
	logic [8:0]  lcnt_q;
	logic [8:0]  lper_q;
	logic        lper_tgl_q;
	logic        per_valid;
	logic [8:0]  per_word;
	aupf_sample_t smp_a;
	aupf_sample_t smp_b;
	logic        tgl_a;
	logic        tgl_b;
	logic        ol_used;
	logic        tbl_ok;
	logic        cfg1_ok;
	logic        fmt_ok;
	logic        mode_err_d;
	logic        rate_ok;
	aupf_ratio_t tbl_main;
	aupf_speed_t ext_speed;

	// resets: async assert, release through two flops per domain
	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	always_ff @(posedge I_EXT_ADC_BIT_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			lrst_meta_q <= 1'b0;
			lrst_n_q    <= 1'b0;
		end else begin
			lrst_meta_q <= 1'b1;
			lrst_n_q    <= lrst_meta_q;
		end
	end

	always_ff @(posedge I_EXT_ADC_BIT_CLOCK or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			sel_meta_q <= EXT_CLK_AUX;
			sel_q      <= EXT_CLK_AUX;
		end else begin
			sel_meta_q <= I_CONFIG.ext_clk_sel;
			sel_q      <= sel_meta_q;
		end
	end

	// only the clock-source bit reaches the capture path, so no port
	// format setting can alter how the external words are framed
	assign ext_frame = (sel_q == EXT_CLK_MAIN) ? // RL11
		I_CODEC_PORT_FRAME_CLOCK : I_AUX_PORT_FRAME_CLOCK; // RL12 RL7

	aupf_adc_deser u_deser_a (
		.i_clk    (I_EXT_ADC_BIT_CLOCK),
		.i_rst_n  (lrst_n_q),
		.i_frame  (ext_frame),
		.i_data   (I_EXT_ADC_DATA_IN_A),
		.o_sample (smp_a),
		.o_toggle (tgl_a)
	);

	aupf_adc_deser u_deser_b (
		.i_clk    (I_EXT_ADC_BIT_CLOCK),
		.i_rst_n  (lrst_n_q),
		.i_frame  (ext_frame),
		.i_data   (I_EXT_ADC_DATA_IN_B),
		.o_sample (smp_b),
		.o_toggle (tgl_b)
	);

	// bit clocks per frame; the first partial frame after reset is dropped
	always_ff @(posedge I_EXT_ADC_BIT_CLOCK or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			lframe_q   <= 1'b0;
			armed_q    <= 1'b0;
			lcnt_q     <= PERIOD_ONE;
			lper_q     <= '0;
			lper_tgl_q <= 1'b0;
		end else begin
			lframe_q <= ext_frame;
			if (ext_frame && !lframe_q) begin
				armed_q <= 1'b1;
				lcnt_q  <= PERIOD_ONE;
				if (armed_q) begin
					lper_q     <= lcnt_q;
					lper_tgl_q <= ~lper_tgl_q;
				end
			end else if (lcnt_q != PERIOD_MAX) begin
				lcnt_q <= lcnt_q + PERIOD_ONE;
			end
		end
	end

	aupf_word_cdc #(.W(ADC_WORD_BITS + 1)) u_cdc_a (
		.i_dst_clk   (I_CLOCK),
		.i_dst_rst_n (rst_n_q),
		.i_word      (smp_a),
		.i_toggle    (tgl_a),
		.o_word      (O_EXT_ADC_A),
		.o_valid     (O_EXT_ADC_A_VALID)
	);

	aupf_word_cdc #(.W(ADC_WORD_BITS + 1)) u_cdc_b (
		.i_dst_clk   (I_CLOCK),
		.i_dst_rst_n (rst_n_q),
		.i_word      (smp_b),
		.i_toggle    (tgl_b),
		.o_word      (O_EXT_ADC_B),
		.o_valid     (O_EXT_ADC_B_VALID)
	);

	aupf_word_cdc #(.W(9)) u_cdc_per (
		.i_dst_clk   (I_CLOCK),
		.i_dst_rst_n (rst_n_q),
		.i_word      (lper_q),
		.i_toggle    (lper_tgl_q),
		.o_word      (per_word),
		.o_valid     (per_valid)
	);

	function automatic logic ratio_ok(input aupf_fmt_t f, input logic w,
			input aupf_speed_t s, input logic m, input aupf_ratio_t r);
		logic wide;
		logic ss;
		wide = (f == FMT_RIGHT24) || (w && f != FMT_RIGHT16);
		ss   = s == SPD_SINGLE;
		if (s == SPD_RSVD) begin
			ratio_ok = 1'b0;
		end else if (m) begin
			ratio_ok = r == RATIO_64 ||
				(ss && wide && (r == RATIO_128 || r == RATIO_256));
		end else if (wide) begin
			ratio_ok = r == RATIO_48 || r == RATIO_64 ||
				(ss && r == RATIO_128);
		end else if (f == FMT_I2S) begin
			ratio_ok = r == RATIO_64 ||
				(ss && (r == RATIO_48 || r == RATIO_128));
		end else begin
			ratio_ok = r == RATIO_32 || r == RATIO_64 ||
				(ss && (r == RATIO_48 || r == RATIO_128));
		end
	endfunction : ratio_ok

	assign fmt_ok = ratio_ok(I_CONFIG.fmt, I_CONFIG.wide_samples, // RL1 RL2
		I_CONFIG.main_speed, I_CONFIG.main_master, I_CONFIG.main_ratio) &&
		ratio_ok(I_CONFIG.fmt, I_CONFIG.wide_samples, // RL3 RL21
		I_CONFIG.aux_speed, I_CONFIG.aux_master, I_CONFIG.aux_ratio);

	always_comb begin
		ol_used  = I_CONFIG.adc_line != OL_NONE ||
			I_CONFIG.dac_line != OL_NONE;
		tbl_ok   = 1'b0;
		tbl_main = RATIO_64;
		case ({I_CONFIG.adc_line, I_CONFIG.dac_line})
			{OL_NONE, OL_NONE}: begin
				tbl_ok = I_CONFIG.main_speed != SPD_RSVD;
			end
			{OL_NONE, OL_MODE1}, {OL_MODE1, OL_NONE},
			{OL_MODE1, OL_MODE1}: begin
				tbl_ok   = I_CONFIG.main_speed == SPD_SINGLE || // RL4
					I_CONFIG.main_speed == SPD_DOUBLE;
				tbl_main = RATIO_128;
			end
			{OL_MODE2, OL_NONE}, {OL_MODE2, OL_MODE2}: begin
				tbl_ok   = I_CONFIG.main_speed == SPD_SINGLE; // RL5 RL20
				tbl_main = RATIO_256;
			end
			default: begin
				tbl_ok = 1'b0; // RL20 RL22
			end
		endcase
		cfg1_ok = I_CONFIG.main_master && I_CONFIG.aux_master && // RL17 RL18
			I_CONFIG.ext_clk_sel == EXT_CLK_AUX && // RL19
			I_CONFIG.main_speed == I_CONFIG.aux_speed && // RL15
			I_CONFIG.adc_port_sel == SEL_ADC_MAIN;
		// only select codes 00 and 10 have a defined data routing
		mode_err_d = (ol_used && !(tbl_ok && cfg1_ok)) || // RL22
			(I_CONFIG.adc_port_sel != SEL_ADC_MAIN &&
			I_CONFIG.adc_port_sel != SEL_ADC_AUX);
	end

	always_ff @(posedge I_CLOCK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			O_MODE_ERROR     <= 1'b0;
			O_FORMAT_ERROR   <= 1'b0;
			O_CONFIG1_ACTIVE <= 1'b0;
			O_MAIN_BIT_RATIO <= RATIO_NONE;
			O_AUX_BIT_RATIO  <= RATIO_NONE;
		end else begin
			O_MODE_ERROR     <= mode_err_d;
			O_FORMAT_ERROR   <= !ol_used && !fmt_ok;
			O_CONFIG1_ACTIVE <= ol_used && !mode_err_d;
			if (ol_used) begin
				O_MAIN_BIT_RATIO <= mode_err_d ? RATIO_NONE : tbl_main; // RL20
				O_AUX_BIT_RATIO  <= mode_err_d ? RATIO_NONE : RATIO_64;
			end else begin
				O_MAIN_BIT_RATIO <= I_CONFIG.main_master ?
					I_CONFIG.main_ratio : RATIO_NONE;
				O_AUX_BIT_RATIO  <= I_CONFIG.aux_master ?
					I_CONFIG.aux_ratio : RATIO_NONE;
			end
		end
	end

	always_ff @(posedge I_CLOCK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			O_LINE_SAMPLE_BITS <= '0;
			O_DAC_CHANNELS     <= '0;
			O_ADC_CHANNELS     <= '0;
			O_SPDIF_CHANNELS   <= '0;
		end else if (ol_used && !mode_err_d) begin
			O_DAC_CHANNELS   <= CFG1_DAC_CH; // RL13
			O_ADC_CHANNELS   <= CFG1_ADC_CH;
			O_SPDIF_CHANNELS <= CFG1_SPDIF_CH;
			if (I_CONFIG.adc_line == OL_MODE2 ||
					I_CONFIG.dac_line == OL_MODE2) begin
				O_LINE_SAMPLE_BITS <= LINE2_BITS; // RL14 RL5
			end else begin
				O_LINE_SAMPLE_BITS <= LINE1_BITS; // RL4
			end
		end else begin
			O_LINE_SAMPLE_BITS <= '0;
			O_DAC_CHANNELS     <= '0;
			O_ADC_CHANNELS     <= '0;
			O_SPDIF_CHANNELS   <= '0;
		end
	end

	// external adc clock rate against the speed of its source port
	assign ext_speed = (I_CONFIG.ext_clk_sel == EXT_CLK_MAIN) ?
		I_CONFIG.main_speed : I_CONFIG.aux_speed;
	assign rate_ok = (ext_speed == SPD_SINGLE && // RL8
		(per_word == PERIOD_64 || per_word == PERIOD_128)) ||
		(ext_speed == SPD_DOUBLE && per_word == PERIOD_64); // RL9 RL10

	always_ff @(posedge I_CLOCK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			O_EXT_ADC_RATE_ERROR <= 1'b0;
			O_EXT_ADC_PERIOD     <= '0;
		end else if (per_valid) begin
			O_EXT_ADC_RATE_ERROR <= !rate_ok;
			O_EXT_ADC_PERIOD     <= per_word;
		end
	end

	always_ff @(posedge I_CLOCK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			O_CODEC_PORT_DATA_OUT <= 1'b0;
			O_AUX_PORT_DATA_OUT   <= 1'b0;
		end else if (I_CONFIG.adc_port_sel == SEL_ADC_MAIN) begin
			O_CODEC_PORT_DATA_OUT <= I_ADC_STREAM_BIT; // RL16
			O_AUX_PORT_DATA_OUT   <= I_SPDIF_STREAM_BIT;
		end else if (I_CONFIG.adc_port_sel == SEL_ADC_AUX) begin
			O_CODEC_PORT_DATA_OUT <= 1'b0;
			O_AUX_PORT_DATA_OUT   <= I_ADC_STREAM_BIT;
		end else begin
			O_CODEC_PORT_DATA_OUT <= 1'b0;
			O_AUX_PORT_DATA_OUT   <= 1'b0;
		end
	end

	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!rst_n_q);

	sequence ol2_cfg_s;
		I_CONFIG.adc_line == OL_MODE2 && I_CONFIG.dac_line == OL_NONE &&
		I_CONFIG.main_speed == SPD_SINGLE && cfg1_ok;
	endsequence

	sequence dac2_bad_s;
		I_CONFIG.dac_line == OL_MODE2 && I_CONFIG.adc_line != OL_MODE2;
	endsequence

	route_main_a: assert property (I_CONFIG.adc_port_sel == SEL_ADC_MAIN // RL16
		|=> O_CODEC_PORT_DATA_OUT == $past(I_ADC_STREAM_BIT) &&
		O_AUX_PORT_DATA_OUT == $past(I_SPDIF_STREAM_BIT))
		else $error("adc or s/pdif data on the wrong output");
	dac_mode2_a: assert property (dac2_bad_s |=> O_MODE_ERROR) // RL22
		else $error("dac mode 2 without adc mode 2 not flagged");
	adc2_ratio_a: assert property (ol2_cfg_s // RL20
		|=> O_MAIN_BIT_RATIO == RATIO_256 && O_AUX_BIT_RATIO == RATIO_64
		&& O_LINE_SAMPLE_BITS == LINE2_BITS && !O_MODE_ERROR)
		else $error("adc mode 2 ratios wrong");
	line1_quad_a: assert property (I_CONFIG.adc_line == OL_MODE1 && // RL4
		I_CONFIG.main_speed == SPD_QUAD |=> O_MODE_ERROR)
		else $error("mode 1 at quad speed not flagged");
	cfg1_master_a: assert property (ol_used && !I_CONFIG.aux_master // RL18
		|=> O_MODE_ERROR && !O_CONFIG1_ACTIVE)
		else $error("config 1 accepted with aux port as slave");
	ext_quad_a: assert property (per_valid && ext_speed == SPD_QUAD // RL10
		|=> O_EXT_ADC_RATE_ERROR)
		else $error("external adc at quad speed not flagged");
	ext_double_a: assert property (per_valid && ext_speed == SPD_DOUBLE // RL9
		&& per_word == PERIOD_128 |=> O_EXT_ADC_RATE_ERROR)
		else $error("128 fs at double speed not flagged");
	ext_single_a: assert property (per_valid && ext_speed == SPD_SINGLE // RL8
		&& per_word == PERIOD_128 |=> !O_EXT_ADC_RATE_ERROR
		&& O_EXT_ADC_PERIOD == PERIOD_128)
		else $error("128 fs at single speed rejected");
	cfg1_count_a: assert property (ol_used && !mode_err_d // RL13
		|=> O_DAC_CHANNELS == CFG1_DAC_CH && O_ADC_CHANNELS == CFG1_ADC_CH)
		else $error("config 1 channel counts wrong");
endmodule : aupf_serial_port

// ==== logic/aupf_word_cdc.sv ====
`timescale 1ns/1ps
// word crossing by toggle; the source holds the word until its next toggle
module aupf_word_cdc #(
	parameter int W = 25
) (
	input  wire logic         i_dst_clk,
	input  wire logic         i_dst_rst_n,
	input  wire logic [W-1:0] i_word,
	input  wire logic         i_toggle,
	output logic      [W-1:0] o_word,
	output logic              o_valid
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	always_ff @(posedge i_dst_clk or negedge i_dst_rst_n) begin
		if (!i_dst_rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= i_toggle;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	always_ff @(posedge i_dst_clk or negedge i_dst_rst_n) begin
		if (!i_dst_rst_n) begin
			o_word  <= '0;
			o_valid <= 1'b0;
		end else begin
			o_valid <= sync_q ^ last_q;
			if (sync_q ^ last_q) begin
				o_word <= i_word;
			end
		end
	end
endmodule : aupf_word_cdc
